// File: logic/awcrs_pkg.sv
// Purpose: Constants for the converter window compare and reference select block
// Assumes: Byte address of a register is four times its index
// Notes:   Registers are eight bits wide in the low lane of a 32-bit word
//
// Overview of operation
// R1: Less-than bound low byte is a full eight-bit read/write register.
// R2: Less-than bound is high byte register joined above low byte register.
// R3: Lower bound above upper bound: flag when result inside both bounds strictly.
// R4: Lower bound below upper bound: flag when result strictly outside either bound.
// R5: Reference field code 00 selects external pin, 11 supply, 01 reserved.
// R6: Upper six bits of reference control read zero, writes ignored.
// R7: Right justified data splits low eight and high four bits; compare uses it.
// R8: Greater-than bound has high and low byte registers like the less-than.
// R9: Window checked once per conversion; flag stays until software clears it.
package awcrs_pkg;
  localparam int          ADDR_W          = 12;
  localparam int          RESULT_W        = 12;
  // Register indices, byte address is index times four
  localparam logic [7:0]  IDX_RESULT_LOW  = 8'hbe;
  localparam logic [7:0]  IDX_RESULT_HIGH = 8'hbf;
  localparam logic [7:0]  IDX_LT_LOW      = 8'hc4;
  localparam logic [7:0]  IDX_GT_HIGH     = 8'hc5;
  localparam logic [7:0]  IDX_LT_HIGH     = 8'hc7;
  localparam logic [7:0]  IDX_GT_LOW      = 8'hce;
  localparam logic [7:0]  IDX_REF_CTRL    = 8'hd1;
  localparam logic [7:0]  IDX_IRQ_STATUS  = 8'hf8;
  localparam logic [7:0]  IDX_IRQ_MASK    = 8'hf9;
  localparam logic [7:0]  IDX_CONFIG      = 8'hfa;
  // Field positions
  localparam int          REF_FIELD_W     = 2;
  localparam int          STAT_WIN_BIT    = 0;
  localparam int          STAT_CONV_BIT   = 1;
  localparam int          STAT_W          = 2;
  localparam int          CFG_LJUST_BIT   = 0;
  // Reset values
  localparam logic [7:0]  RST_BOUND       = 8'h00;
  localparam logic [1:0]  RST_REF_FIELD   = 2'h0;
  localparam logic [1:0]  RST_STAT        = 2'h0;
  localparam logic [1:0]  RST_MASK        = 2'h0;
  localparam logic [11:0] RST_RESULT      = 12'h000;
  // Reference source codes
  localparam logic [1:0]  REF_EXTERNAL    = 2'h0;
  localparam logic [1:0]  REF_RESERVED    = 2'h1;
  localparam logic [1:0]  REF_SUPPLY      = 2'h3;
  // Bus responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : awcrs_pkg

// File: logic/awcrs_window_cmp.sv
// Purpose: Window decision on one right-justified conversion word
// Assumes: Bounds and result are unsigned
// Notes:   Purely combinational
`timescale 1ns/1ps
module awcrs_window_cmp #(
  parameter int RESULT_W = 12
) (
  input  wire logic [RESULT_W-1:0] result,
  input  wire logic [15:0]         lt_bound,
  input  wire logic [15:0]         gt_bound,
  output logic                     hit
);
  wire logic [15:0] result_wide;
  wire logic        below_lt;
  wire logic        above_gt;
  wire logic        inside_mode;

  assign result_wide = 16'(result);
  assign below_lt    = result_wide < lt_bound;
  assign above_gt    = result_wide > gt_bound;
  assign inside_mode = lt_bound > gt_bound;
  // R3 R4: inside or outside window
  assign hit = inside_mode ? (below_lt & above_gt) : (below_lt | above_gt);
endmodule : awcrs_window_cmp

// File: logic/awcrs_top.sv
// Purpose: Window compare and reference select with AXI4-Lite registers
// Assumes: conv_done is a one-cycle pulse with conv_result valid alongside
// Notes:   Interrupt status is write-one-to-clear; a new event wins a clear
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module awcrs_top #(
  parameter int RESULT_W = 12
) (
  input  wire logic                        core_clk,
  input  wire logic                        rstn,
  input  wire logic [awcrs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [awcrs_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        conv_done,
  input  wire logic [RESULT_W-1:0]         conv_result,
  output logic [1:0]                       reference_source_field,
  output logic                             window_hit_flag,
  output logic                             irq
);
  if (RESULT_W != awcrs_pkg::RESULT_W) begin : g_bad_width
    $error("Only a twelve-bit result is supported");
  end

  // Register state
  logic [7:0]                  lt_low_reg;
  logic [7:0]                  lt_high_reg;
  logic [7:0]                  gt_low_reg;
  logic [7:0]                  gt_high_reg;
  logic [1:0]                  ref_field_reg;
  logic [awcrs_pkg::STAT_W-1:0] status_reg;
  logic [awcrs_pkg::STAT_W-1:0] status_next;
  logic [awcrs_pkg::STAT_W-1:0] mask_reg;
  logic                        ljust_reg;
  logic [RESULT_W-1:0]         result_reg;

  // Bus state
  logic                        aw_full_reg;
  logic                        w_full_reg;
  logic [7:0]                  aw_idx_reg;
  logic                        aw_low_reg;
  logic [31:0]                 wdata_reg;
  logic                        wstrb0_reg;
  logic                        bvalid_reg;
  logic [1:0]                  bresp_reg;
  logic                        rvalid_reg;
  logic [31:0]                 rdata_reg;
  logic [1:0]                  rresp_reg;

  // Decode
  wire logic                   wr_fire;
  wire logic                   wr_en;
  wire logic [7:0]             wr_byte;
  wire logic                   wr_hit;
  wire logic [7:0]             ar_idx;
  wire logic                   ar_aligned;
  wire logic [7:0]             rd_byte;
  wire logic                   rd_hit;
  wire logic [15:0]            lt_bound;
  wire logic [15:0]            gt_bound;
  wire logic                   win_hit;
  wire logic [15:0]            result_word;
  wire logic [7:0]             data_low;
  wire logic [7:0]             data_high;
  wire logic [awcrs_pkg::STAT_W-1:0] events;
  wire logic [awcrs_pkg::STAT_W-1:0] w1c;

  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready  = ~w_full_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  assign wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wr_en   = wr_fire & wstrb0_reg & aw_low_reg;
  assign wr_byte = wdata_reg[7:0];
  assign wr_hit  = aw_low_reg & (aw_idx_reg == awcrs_pkg::IDX_LT_LOW
                || aw_idx_reg == awcrs_pkg::IDX_LT_HIGH
                || aw_idx_reg == awcrs_pkg::IDX_GT_LOW
                || aw_idx_reg == awcrs_pkg::IDX_GT_HIGH
                || aw_idx_reg == awcrs_pkg::IDX_REF_CTRL
                || aw_idx_reg == awcrs_pkg::IDX_IRQ_STATUS
                || aw_idx_reg == awcrs_pkg::IDX_IRQ_MASK
                || aw_idx_reg == awcrs_pkg::IDX_CONFIG
                || aw_idx_reg == awcrs_pkg::IDX_RESULT_LOW
                || aw_idx_reg == awcrs_pkg::IDX_RESULT_HIGH);

  // R2 R8: sixteen-bit bounds
  assign lt_bound = {lt_high_reg, lt_low_reg};
  assign gt_bound = {gt_high_reg, gt_low_reg};

  // R7: data placement by justification
  assign result_word = ljust_reg ? {result_reg, 4'h0} : 16'(result_reg);
  assign data_low    = result_word[7:0];
  assign data_high   = result_word[15:8];

  assign ar_idx     = s_axi_araddr[9:2];
  assign ar_aligned = (s_axi_araddr[1:0] == 2'h0) & (s_axi_araddr[11:10] == 2'h0);
  assign rd_hit     = ar_aligned & (ar_idx == awcrs_pkg::IDX_LT_LOW
                   || ar_idx == awcrs_pkg::IDX_LT_HIGH
                   || ar_idx == awcrs_pkg::IDX_GT_LOW
                   || ar_idx == awcrs_pkg::IDX_GT_HIGH
                   || ar_idx == awcrs_pkg::IDX_REF_CTRL
                   || ar_idx == awcrs_pkg::IDX_IRQ_STATUS
                   || ar_idx == awcrs_pkg::IDX_IRQ_MASK
                   || ar_idx == awcrs_pkg::IDX_CONFIG
                   || ar_idx == awcrs_pkg::IDX_RESULT_LOW
                   || ar_idx == awcrs_pkg::IDX_RESULT_HIGH);
  // R6: unused reference bits read zero
  assign rd_byte =
      (ar_idx == awcrs_pkg::IDX_LT_LOW)      ? lt_low_reg :
      (ar_idx == awcrs_pkg::IDX_LT_HIGH)     ? lt_high_reg :
      (ar_idx == awcrs_pkg::IDX_GT_LOW)      ? gt_low_reg :
      (ar_idx == awcrs_pkg::IDX_GT_HIGH)     ? gt_high_reg :
      (ar_idx == awcrs_pkg::IDX_REF_CTRL)    ? {6'h00, ref_field_reg} :
      (ar_idx == awcrs_pkg::IDX_IRQ_STATUS)  ? {6'h00, status_reg} :
      (ar_idx == awcrs_pkg::IDX_IRQ_MASK)    ? {6'h00, mask_reg} :
      (ar_idx == awcrs_pkg::IDX_CONFIG)      ? {7'h00, ljust_reg} :
      (ar_idx == awcrs_pkg::IDX_RESULT_LOW)  ? data_low :
      (ar_idx == awcrs_pkg::IDX_RESULT_HIGH) ? data_high : 8'h00;

  awcrs_window_cmp #(
    .RESULT_W (RESULT_W)
  ) u_cmp (
    .result   (conv_result),
    .lt_bound (lt_bound),
    .gt_bound (gt_bound),
    .hit      (win_hit)
  );

  // R9: one check per conversion, sticky
  assign events[awcrs_pkg::STAT_WIN_BIT]  = conv_done & win_hit;
  assign events[awcrs_pkg::STAT_CONV_BIT] = conv_done;
  assign w1c = (wr_en && aw_idx_reg == awcrs_pkg::IDX_IRQ_STATUS)
             ? wr_byte[awcrs_pkg::STAT_W-1:0] : '0;
  assign status_next = (status_reg & ~w1c) | events;

  assign window_hit_flag        = status_reg[awcrs_pkg::STAT_WIN_BIT];
  assign irq                    = |(status_reg & mask_reg);
  assign reference_source_field = ref_field_reg;

  // Write address and data capture
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aw_full_reg <= 1'b0;
      aw_idx_reg  <= 8'h00;
      aw_low_reg  <= 1'b0;
    end else if (s_axi_awvalid && !aw_full_reg) begin
      aw_full_reg <= 1'b1;
      aw_idx_reg  <= s_axi_awaddr[9:2];
      aw_low_reg  <= (s_axi_awaddr[1:0] == 2'h0) & (s_axi_awaddr[11:10] == 2'h0);
    end else if (wr_fire) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      w_full_reg <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb0_reg <= 1'b0;
    end else if (s_axi_wvalid && !w_full_reg) begin
      w_full_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb0_reg <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_full_reg <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= awcrs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? awcrs_pkg::RESP_OKAY : awcrs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= awcrs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {24'h000000, rd_hit ? rd_byte : 8'h00};
      rresp_reg  <= rd_hit ? awcrs_pkg::RESP_OKAY : awcrs_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // R1 R8: bound byte registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lt_low_reg  <= awcrs_pkg::RST_BOUND;
      lt_high_reg <= awcrs_pkg::RST_BOUND;
      gt_low_reg  <= awcrs_pkg::RST_BOUND;
      gt_high_reg <= awcrs_pkg::RST_BOUND;
    end else if (wr_en) begin
      if (aw_idx_reg == awcrs_pkg::IDX_LT_LOW) lt_low_reg <= wr_byte;
      if (aw_idx_reg == awcrs_pkg::IDX_LT_HIGH) lt_high_reg <= wr_byte;
      if (aw_idx_reg == awcrs_pkg::IDX_GT_LOW) gt_low_reg <= wr_byte;
      if (aw_idx_reg == awcrs_pkg::IDX_GT_HIGH) gt_high_reg <= wr_byte;
    end
  end

  // R5 R6: reference field, upper bits dropped
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ref_field_reg <= awcrs_pkg::RST_REF_FIELD;
      mask_reg      <= awcrs_pkg::RST_MASK;
      ljust_reg     <= 1'b0;
    end else if (wr_en) begin
      if (aw_idx_reg == awcrs_pkg::IDX_REF_CTRL) ref_field_reg <= wr_byte[1:0];
      if (aw_idx_reg == awcrs_pkg::IDX_IRQ_MASK) mask_reg <= wr_byte[1:0];
      if (aw_idx_reg == awcrs_pkg::IDX_CONFIG) ljust_reg <= wr_byte[awcrs_pkg::CFG_LJUST_BIT];
    end
  end

  // R9: sticky status, set wins clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      status_reg <= awcrs_pkg::RST_STAT;
      result_reg <= awcrs_pkg::RST_RESULT;
    end else begin
      status_reg <= status_next;
      if (conv_done) result_reg <= conv_result;
    end
  end
endmodule : awcrs_top

// File: sim/awcrs_properties.sv
// Purpose: Port properties of the window compare block
// Assumes: Bound to awcrs_top
// Notes:   One clock domain
`timescale 1ns/1ps
module awcrs_checker (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        conv_done,
  input wire logic [1:0]  reference_source_field,
  input wire logic        window_hit_flag,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_flag_set_cause: assert property ($rose(window_hit_flag) |-> $past(conv_done))
    else $error("flag rose without conversion");
  a_flag_clear_cause: assert property ($fell(window_hit_flag) |-> $rose(s_axi_bvalid))
    else $error("flag fell without a write");
  a_ref_change_cause: assert property ($changed(reference_source_field) |-> $rose(s_axi_bvalid))
    else $error("reference changed without a write");
  a_read_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response held after taken");
  a_reset_quiet: assert property ($rose(rstn) |-> !irq && !window_hit_flag)
    else $error("flag or irq set after reset");
endmodule : awcrs_checker
bind awcrs_top awcrs_checker u_chk (.core_clk(core_clk), .rstn(rstn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .s_axi_rready(s_axi_rready),
  .conv_done(conv_done), .reference_source_field(reference_source_field),
  .window_hit_flag(window_hit_flag), .irq(irq));

// File: sim/awcrs_tb.sv
// Purpose: Self-checking bench for the window compare block
// Assumes: Registers are bytes at four times their index
// Notes:   Bus tasks hold each request until taken
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module awcrs_tb;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        conv_done = 1'b0;
  logic [11:0] conv_result = 12'h000;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, reference_source_field;
  logic [31:0] s_axi_rdata;
  logic        window_hit_flag, irq, exp_flag;
  int          n_errors = 0;
  int          compares = 0;
  logic [11:0] res_tab [10] = '{12'h100, 12'h200, 12'h101, 12'h100, 12'h1ff,
                                12'h100, 12'h0ff, 12'h200, 12'h201, 12'h150};
  logic [9:0]  hit_tab = 10'b01_0101_0100;
  logic [1:0]  codes [3] = '{awcrs_pkg::REF_SUPPLY, awcrs_pkg::REF_RESERVED,
                             awcrs_pkg::REF_EXTERNAL};
  always #5 core_clk = ~core_clk;
  awcrs_top u_dut (.core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .conv_done(conv_done), .conv_result(conv_result),
    .reference_source_field(reference_source_field), .window_hit_flag(window_hit_flag),
    .irq(irq));
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHECK("bresp", awcrs_pkg::RESP_OKAY, s_axi_bresp)
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] ex, input logic [1:0] er);
    @(posedge core_clk);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHECK("rdata", {24'h0, ex}, s_axi_rdata)
    `CHECK("rresp", er, s_axi_rresp)
  endtask : rd
  task automatic conv(input logic [11:0] r);
    @(posedge core_clk);
    conv_done <= 1'b1;
    conv_result <= r;
    @(posedge core_clk);
    conv_done <= 1'b0;
    #1;
  endtask : conv
  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  initial begin
    #50us;
    n_errors++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    rd(awcrs_pkg::IDX_REF_CTRL, 8'h00, awcrs_pkg::RESP_OKAY);
    rd(awcrs_pkg::IDX_LT_LOW, 8'h00, awcrs_pkg::RESP_OKAY);
    rd(8'h00, 8'h00, awcrs_pkg::RESP_SLVERR);
    wr(awcrs_pkg::IDX_LT_LOW, 32'hffff_ffa5);
    rd(awcrs_pkg::IDX_LT_LOW, 8'ha5, awcrs_pkg::RESP_OKAY);
    foreach (codes[i]) begin
      wr(awcrs_pkg::IDX_REF_CTRL, {24'h0, 6'h3f, codes[i]});
      rd(awcrs_pkg::IDX_REF_CTRL, {6'h00, codes[i]}, awcrs_pkg::RESP_OKAY);
      `CHECK("ref field", codes[i], reference_source_field)
    end
    for (int i = 0; i < 10; i++) begin
      if (i == 0 || i == 5) begin
        wr(awcrs_pkg::IDX_IRQ_STATUS, 32'h3);
        wr(awcrs_pkg::IDX_LT_HIGH, (i == 0) ? 32'h2 : 32'h1);
        wr(awcrs_pkg::IDX_LT_LOW, 32'h0);
        wr(awcrs_pkg::IDX_GT_HIGH, (i == 0) ? 32'h1 : 32'h2);
        wr(awcrs_pkg::IDX_GT_LOW, 32'h0);
        wr(awcrs_pkg::IDX_IRQ_MASK, (i == 0) ? 32'h0 : 32'h1);
        exp_flag = 1'b0;
      end
      conv(res_tab[i]);
      exp_flag = exp_flag | hit_tab[i];
      `CHECK("window flag", exp_flag, window_hit_flag)
      `CHECK("irq", exp_flag & (i > 4), irq)
      if (i > 4 && hit_tab[i]) begin
        wr(awcrs_pkg::IDX_IRQ_STATUS, 32'h3);
        exp_flag = 1'b0;
      end
    end
    rd(awcrs_pkg::IDX_RESULT_LOW, 8'h50, awcrs_pkg::RESP_OKAY);
    rd(awcrs_pkg::IDX_RESULT_HIGH, 8'h01, awcrs_pkg::RESP_OKAY);
    wr(awcrs_pkg::IDX_CONFIG, 32'h1);
    conv(12'h150);
    `CHECK("window flag ljust", 1'b0, window_hit_flag)
    rd(awcrs_pkg::IDX_RESULT_LOW, 8'h00, awcrs_pkg::RESP_OKAY);
    rd(awcrs_pkg::IDX_RESULT_HIGH, 8'h15, awcrs_pkg::RESP_OKAY);
    rd(awcrs_pkg::IDX_IRQ_STATUS, 8'h02, awcrs_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'h0;
    wr(awcrs_pkg::IDX_LT_HIGH, 32'hee);
    s_axi_wstrb <= 4'hf;
    rd(awcrs_pkg::IDX_LT_HIGH, 8'h01, awcrs_pkg::RESP_OKAY);
    wr(awcrs_pkg::IDX_REF_CTRL, 32'h3);
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    `CHECK("ref after reset", awcrs_pkg::RST_REF_FIELD, reference_source_field)
    rd(awcrs_pkg::IDX_IRQ_STATUS, 8'h00, awcrs_pkg::RESP_OKAY);
    conclude();
  end
endmodule : awcrs_tb
